// file: bench/dbg_gpio_top_test.sv
`include "dbg_defines.svh"

module dbg_gpio_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, por_reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, m_osc;
  logic [7:0]  third_pin_in, third_pin_out, third_pin_oe, fourth_pin_in, fourth_pin_out, fourth_pin_oe;
  logic [7:0]  second_port_direction, weak_pullup_on, m_pu;
  logic [7:0]  m_lat[2], m_dir[2], m_pe[2], m_po[2], m_lcd[2], m_ext[2];
  logic        m_ue, m_uo, m_se, m_so, m_bias, m_g;
  logic [11:0] pins_a[2], dir_a[2];
  int          n_mismatch, total_checks, cyc;

  dbg_gpio_top i_dbg_gpio_top (
    .aclk, .aresetn, .por_reset, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .third_pin_in, .third_pin_out, .third_pin_oe, .fourth_pin_in, .fourth_pin_out,
    .fourth_pin_oe, .third_periph_en(m_pe[0]), .third_periph_out(m_po[0]), .usart_tx_en(m_ue),
    .usart_tx_out(m_uo), .synchronous_serial_port_en(m_se), .synchronous_serial_port_out(m_so),
    .third_lcd_seg_en(m_lcd[0]),
    .lcd_bias_input_en(m_bias), .fourth_periph_en(m_pe[1]), .fourth_periph_out(m_po[1]),
    .fourth_lcd_seg_en(m_lcd[1]), .second_port_direction, .weak_pullup_on
  );
  dbg_pin_model i_pins_three (.pin_out(third_pin_out), .pin_oe(third_pin_oe), .ext_level(m_ext[0]),
    .pin_in(third_pin_in));
  dbg_pin_model i_pins_four (.pin_out(fourth_pin_out), .pin_oe(fourth_pin_oe), .ext_level(m_ext[1]),
    .pin_in(fourth_pin_in));

  always #5 aclk = ~aclk;

  // Cuts a hang short; the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Expected drive: peripheral and serial enables win over direction, LCD ownership over all
  function automatic logic [7:0] e_oe(int p);
    logic [7:0] o;
    o = m_pe[p] | ~m_dir[p];
    if (p == 0) begin
      o[6] = m_ue | m_se | ~m_dir[0][6];
      if (m_bias) o[2:0] = 3'h0;
    end
    return o & ~m_lcd[p];
  endfunction

  function automatic logic [7:0] e_out(int p);
    logic [7:0] o;
    o = (m_pe[p] & m_po[p]) | (~m_pe[p] & m_lat[p]);
    if (p == 0) o[6] = m_ue ? m_uo : (m_se ? m_so : m_lat[0][6]);
    return o;
  endfunction

  task automatic check_pins;
    chk("third_oe", {24'h0, third_pin_oe}, {24'h0, e_oe(0)});
    chk("third_out", {24'h0, third_pin_out & e_oe(0)}, {24'h0, e_out(0) & e_oe(0)});
    chk("fourth_oe", {24'h0, fourth_pin_oe}, {24'h0, e_oe(1)});
    chk("fourth_out", {24'h0, fourth_pin_out & e_oe(1)}, {24'h0, e_out(1) & e_oe(1)});
    chk("pullup", {24'h0, weak_pullup_on}, {24'h0, {8{m_g}} & m_pu & second_port_direction});
  endtask

  task automatic check_reads;
    for (int p = 0; p < 2; p++) begin
      rd(pins_a[p], d, r);
      chk("pins_read", d, {24'h0, (e_oe(p) & e_out(p)) | (~e_oe(p) & m_ext[p])});
      chk("pins_rresp", {30'h0, r}, {30'h0, `DBG_RESP_OKAY});
      rd(dir_a[p], d, r);
      chk("dir_read", d, {24'h0, m_dir[p] | ((m_osc != 2'h2) ? 8'hC0 : 8'h00)});
      chk("dir_rresp", {30'h0, r}, {30'h0, `DBG_RESP_OKAY});
    end
  endtask

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, m_ue, m_uo, m_se, m_so, m_bias, m_g} = '0;
    {awaddr, araddr, wdata, cyc, n_mismatch, total_checks} = '0;
    {por_reset, wstrb, m_osc, m_pu, second_port_direction} = {1'h1, 4'hF, 2'h2, 8'hFF, 8'h00};
    pins_a = '{`DBG_BYTE_ADDR(`DBG_IDX_THIRD_PINS), `DBG_BYTE_ADDR(`DBG_IDX_FOURTH_PINS)};
    dir_a = '{`DBG_BYTE_ADDR(`DBG_IDX_THIRD_DIR), `DBG_BYTE_ADDR(`DBG_IDX_FOURTH_DIR)};
    m_lat = '{8'h00, 8'h00};
    m_dir = '{8'hFF, 8'hFF};
    m_pe = '{8'h00, 8'h00};
    m_po = '{8'h00, 8'h00};
    m_lcd = '{8'h00, 8'h00};
    m_ext = '{8'h5A, 8'hA5};
    void'($urandom(27982));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    por_reset <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check_pins();
    check_reads();
    for (int it = 0; it < 24; it++) begin
      @(posedge aclk);
      m_osc <= 2'($urandom);
      m_pu <= 8'($urandom);
      m_g <= 1'($urandom);
      second_port_direction <= 8'($urandom);
      {m_ue, m_uo, m_se, m_so} <= 4'($urandom);
      m_bias <= ($urandom % 4 == 0);
      for (int p = 0; p < 2; p++) begin
        m_lat[p] <= 8'($urandom);
        m_dir[p] <= 8'($urandom);
        m_pe[p] <= 8'($urandom & $urandom & $urandom);
        m_po[p] <= 8'($urandom);
        m_lcd[p] <= 8'($urandom & $urandom & $urandom);
        m_ext[p] <= 8'($urandom);
      end
      @(negedge aclk);
      for (int p = 0; p < 2; p++) begin
        wr(pins_a[p], {24'h0, m_lat[p]}, r);
        chk("write_resp", {30'h0, r}, {30'h0, `DBG_RESP_OKAY});
        wr(dir_a[p], {24'h0, m_dir[p]}, r);
      end
      wr(`DBG_BYTE_ADDR(`DBG_IDX_CONFIG), {15'h0, m_g, m_pu, 6'h0, m_osc}, r);
      chk("config_resp", {30'h0, r}, {30'h0, `DBG_RESP_OKAY});
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      check_pins();
      check_reads();
    end
    // Unmapped place: refused without side effects
    rd(12'h104, d, r);
    chk("unmapped_rresp", {30'h0, r}, {30'h0, `DBG_RESP_SLVERR});
    chk("unmapped_rdata", d, 32'h0);
    wr(12'h104, 32'hFFFF_FFFF, r);
    chk("unmapped_bresp", {30'h0, r}, {30'h0, `DBG_RESP_SLVERR});
    // Warm reset keeps latches but reloads directions
    @(posedge aclk);
    aresetn <= 1'b0;
    {m_ue, m_se, m_bias, m_g, m_osc, m_pu} <= {4'h0, 2'h2, 8'hFF};
    m_pe <= '{8'h00, 8'h00};
    m_lcd <= '{8'h00, 8'h00};
    m_dir <= '{8'hFF, 8'hFF};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check_pins();
    check_reads();
    m_dir = '{8'h00, 8'h00};
    for (int p = 0; p < 2; p++) wr(dir_a[p], 32'h0, r);
    @(negedge aclk);
    check_pins();
    print_verdict();
  end
endmodule

// file: bench/dbg_pin_model.sv
module dbg_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Far side yields where the device drives; clean levels, as after a Schmitt buffer
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// file: core/dbg_defines.svh
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH

// Register indices; byte address is four times the index
`define DBG_IDX_THIRD_PINS  8'h07
`define DBG_IDX_FOURTH_PINS 8'h08
`define DBG_IDX_THIRD_DIR   8'h87
`define DBG_IDX_FOURTH_DIR  8'h88
`define DBG_IDX_CONFIG      8'h40
`define DBG_ADDR_W          12
`define DBG_BYTE_ADDR(i)    ({2'h0, (i), 2'h0})

// Reset values
`define DBG_DIR_RESET       8'hFF
`define DBG_LATCH_POR       8'h00
`define DBG_PULLUP_RESET    8'hFF
`define DBG_PU_GLOBAL_RESET 1'h0

// Field positions
`define DBG_FORCED_MSB      7
`define DBG_FORCED_LSB      6
`define DBG_FORCED_ONES     2'h3
`define DBG_CFG_OSC_MSB     1
`define DBG_CFG_OSC_LSB     0
`define DBG_CFG_PU_MSB      15
`define DBG_CFG_PU_LSB      8
`define DBG_CFG_PU_GLOBAL   16
`define DBG_SERIAL_PIN      6
`define DBG_BIAS_MSB        2
`define DBG_BIAS_LSB        0

// Bus responses
`define DBG_RESP_OKAY       2'h0
`define DBG_RESP_SLVERR     2'h2

`endif

// file: core/dbg_gpio_top.sv
// Function
// - Third port: eight Schmitt-input bidirectional pins
// - Latch write drives pins set as outputs
// - Third direction bit one is input
// - Oscillator crystal modes: third direction 7:6 read one
// - Data read returns sampled pin levels
// - Pin six: serial, then synchronous port, latch
// - Fourth port: eight individually directed Schmitt pins
// - Fourth direction bit one is input
// - Oscillator crystal modes: fourth direction 7:6 read one
// - Power reset clears latches; others keep them
// - Third port registers at 07h, 87h
// - Fourth port registers at 08h, 88h
// - LCD configuration decides pin drive ownership
// - Third pins 0-2 may be bias inputs
// - Second port pull-up off on outputs
`include "dbg_defines.svh"

module dbg_gpio_top (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   por_reset,
  input  wire logic [`DBG_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`DBG_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [7:0]             third_pin_in,
  output logic [7:0]                  third_pin_out,
  output logic [7:0]                  third_pin_oe,
  input  wire logic [7:0]             fourth_pin_in,
  output logic [7:0]                  fourth_pin_out,
  output logic [7:0]                  fourth_pin_oe,
  input  wire logic [7:0]             third_periph_en,
  input  wire logic [7:0]             third_periph_out,
  input  wire logic                   usart_tx_en,
  input  wire logic                   usart_tx_out,
  input  wire logic                   synchronous_serial_port_en,
  input  wire logic                   synchronous_serial_port_out,
  input  wire logic [7:0]             third_lcd_seg_en,
  input  wire logic                   lcd_bias_input_en,
  input  wire logic [7:0]             fourth_periph_en,
  input  wire logic [7:0]             fourth_periph_out,
  input  wire logic [7:0]             fourth_lcd_seg_en,
  input  wire logic [7:0]             second_port_direction,
  output logic [7:0]                  weak_pullup_on
);

  localparam logic [`DBG_ADDR_W-1:0] A_THIRD_PINS  = `DBG_BYTE_ADDR(`DBG_IDX_THIRD_PINS);
  localparam logic [`DBG_ADDR_W-1:0] A_FOURTH_PINS = `DBG_BYTE_ADDR(`DBG_IDX_FOURTH_PINS);
  localparam logic [`DBG_ADDR_W-1:0] A_THIRD_DIR   = `DBG_BYTE_ADDR(`DBG_IDX_THIRD_DIR);
  localparam logic [`DBG_ADDR_W-1:0] A_FOURTH_DIR  = `DBG_BYTE_ADDR(`DBG_IDX_FOURTH_DIR);
  localparam logic [`DBG_ADDR_W-1:0] A_CONFIG      = `DBG_BYTE_ADDR(`DBG_IDX_CONFIG);

  logic                   aw_held_ff;
  logic [`DBG_ADDR_W-1:0] aw_addr_ff;
  logic                   w_held_ff;
  logic [31:0]            w_data_ff;
  logic [3:0]             w_strb_ff;
  logic                   bvalid_ff;
  logic [1:0]             bresp_ff;
  logic                   rvalid_ff;
  logic [31:0]            rdata_ff;
  logic [1:0]             rresp_ff;
  dbg_pkg::dbg_osc_type   osc_ff;
  logic [7:0]             pullup_en_ff;
  logic                   pullup_global_ff;

  logic [7:0] third_latch;
  logic [7:0] third_dir;
  logic [7:0] third_sync;
  logic [7:0] fourth_latch;
  logic [7:0] fourth_dir;
  logic [7:0] fourth_sync;

  // Write channel: address and data are taken in either order
  wire                   aw_hs    = awvalid && awready;
  wire                   w_hs     = wvalid && wready;
  wire                   have_aw  = aw_held_ff || aw_hs;
  wire                   have_w   = w_held_ff || w_hs;
  wire                   commit   = have_aw && have_w && !bvalid_ff;
  wire [`DBG_ADDR_W-1:0] wr_addr  = aw_held_ff ? aw_addr_ff : awaddr;
  wire [31:0]            wr_data  = w_held_ff ? w_data_ff : wdata;
  wire [3:0]             wr_strb  = w_held_ff ? w_strb_ff : wstrb;
  wire                   wr_lane0 = commit && wr_strb[0];

  wire wr_third_pins  = wr_lane0 && (wr_addr == A_THIRD_PINS);
  wire wr_third_dir   = wr_lane0 && (wr_addr == A_THIRD_DIR);
  wire wr_fourth_pins = wr_lane0 && (wr_addr == A_FOURTH_PINS);
  wire wr_fourth_dir  = wr_lane0 && (wr_addr == A_FOURTH_DIR);
  wire wr_config      = commit && (wr_addr == A_CONFIG);
  wire wr_mapped      = (wr_addr == A_THIRD_PINS) || (wr_addr == A_THIRD_DIR) || (wr_addr == A_FOURTH_PINS) ||
                        (wr_addr == A_FOURTH_DIR) || (wr_addr == A_CONFIG);

  // At most one write in flight; a pending response blocks both channels
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready  = !w_held_ff && !bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff  <= 1'b0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DBG_RESP_OKAY;
    end else begin
      if (commit) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_mapped ? `DBG_RESP_OKAY : `DBG_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= awaddr;
        end
        if (w_hs) begin
          w_held_ff <= 1'b1;
          w_data_ff <= wdata;
          w_strb_ff <= wstrb;
        end
        if (bvalid_ff && bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  // Own configuration word: oscillator mode and second-port pull-ups
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ff           <= dbg_pkg::dbg_osc_rc;
      pullup_en_ff     <= `DBG_PULLUP_RESET;
      pullup_global_ff <= `DBG_PU_GLOBAL_RESET;
    end else if (wr_config) begin
      if (wr_strb[0]) begin
        osc_ff <= dbg_pkg::dbg_osc_type'(wr_data[`DBG_CFG_OSC_MSB:`DBG_CFG_OSC_LSB]);
      end
      if (wr_strb[1]) begin
        pullup_en_ff <= wr_data[`DBG_CFG_PU_MSB:`DBG_CFG_PU_LSB];
      end
      if (wr_strb[2]) begin
        pullup_global_ff <= wr_data[`DBG_CFG_PU_GLOBAL];
      end
    end
  end

  dbg_port_lane #(
    .W (8)
  ) u_third (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .por_reset (por_reset),
    .latch_we  (wr_third_pins),
    .dir_we    (wr_third_dir),
    .wr_data   (wr_data[7:0]),
    .pin_in    (third_pin_in),
    .latch_q   (third_latch),
    .dir_q     (third_dir),
    .pin_sync  (third_sync)
  );

  dbg_port_lane #(
    .W (8)
  ) u_fourth (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .por_reset (por_reset),
    .latch_we  (wr_fourth_pins),
    .dir_we    (wr_fourth_dir),
    .wr_data   (wr_data[7:0]),
    .pin_in    (fourth_pin_in),
    .latch_q   (fourth_latch),
    .dir_q     (fourth_dir),
    .pin_sync  (fourth_sync)
  );

  // Crystal-type oscillators own the top two pins, so their directions read as inputs
  wire       osc_forced     = (osc_ff != dbg_pkg::dbg_osc_rc);
  wire [7:0] third_dir_rd   = osc_forced ? {`DBG_FORCED_ONES, third_dir[5:0]} : third_dir;
  wire [7:0] fourth_dir_rd  = osc_forced ? {`DBG_FORCED_ONES, fourth_dir[5:0]} : fourth_dir;
  wire [31:0] config_rd     = {15'h0, pullup_global_ff, pullup_en_ff, 6'h0, osc_ff};

  wire [31:0] rd_mux =
    (araddr == A_THIRD_PINS)  ? {24'h0, third_sync} :
    (araddr == A_FOURTH_PINS) ? {24'h0, fourth_sync} :
    (araddr == A_THIRD_DIR)   ? {24'h0, third_dir_rd} :
    (araddr == A_FOURTH_DIR)  ? {24'h0, fourth_dir_rd} :
    (araddr == A_CONFIG)      ? config_rd : 32'h0;
  wire rd_mapped = (araddr == A_THIRD_PINS) || (araddr == A_FOURTH_PINS) || (araddr == A_THIRD_DIR) ||
                   (araddr == A_FOURTH_DIR) || (araddr == A_CONFIG);
  wire ar_hs     = arvalid && arready;

  assign arready = !rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= `DBG_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_mapped ? `DBG_RESP_OKAY : `DBG_RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Pad drive; LCD ownership and bias inputs take the digital driver off
  wire [7:0] third_bias = lcd_bias_input_en ? 8'h07 : 8'h00;
  wire [7:0] third_off  = third_lcd_seg_en | third_bias;
  wire [7:0] third_gp_oe  = ~third_off & (third_periph_en | ~third_dir);
  wire [7:0] third_gp_out = (third_periph_en & third_periph_out) | (~third_periph_en & third_latch);
  wire       pin6_src = synchronous_serial_port_en ? synchronous_serial_port_out : third_latch[`DBG_SERIAL_PIN];
  wire       pin6_out = usart_tx_en ? usart_tx_out : pin6_src;
  wire       pin6_oe  = !third_off[`DBG_SERIAL_PIN] &&
                        (usart_tx_en || synchronous_serial_port_en || !third_dir[`DBG_SERIAL_PIN]);

  always_comb begin
    third_pin_out = third_gp_out;
    third_pin_oe  = third_gp_oe;
    third_pin_out[`DBG_SERIAL_PIN] = pin6_out;
    third_pin_oe[`DBG_SERIAL_PIN]  = pin6_oe;
  end

  assign fourth_pin_oe  = ~fourth_lcd_seg_en & (fourth_periph_en | ~fourth_dir);
  assign fourth_pin_out = (fourth_periph_en & fourth_periph_out) | (~fourth_periph_en & fourth_latch);

  // Pull-up would fight an output driver, so output pins never get it
  assign weak_pullup_on = {8{pullup_global_ff}} & pullup_en_ff & second_port_direction;

  a_dir_reset_ones:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (third_dir == 8'hFF) && (fourth_dir == 8'hFF))
    else $error("direction not all ones after reset");

  a_latch_warm_keep:
    assert property (@(posedge aclk)
      !aresetn && !por_reset |=> $stable(third_latch) && $stable(fourth_latch))
    else $error("warm reset changed a data latch");

  a_read_sync_pins:
    assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && (araddr == A_THIRD_PINS) |=> rdata[7:0] == $past(third_pin_in, 3))
    else $error("third port read not two-flop sampled pins");

  a_osc_dir_forced:
    assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && osc_forced && (araddr == A_THIRD_DIR) |=> rdata[7:6] == 2'h3 && rvalid)
    else $error("third direction top bits not forced");

  a_osc_dir_fourth:
    assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && osc_forced && (araddr == A_FOURTH_DIR) |=> rdata[7:6] == 2'h3)
    else $error("fourth direction top bits not forced");

  a_latch_drives_pin:
    assert property (@(posedge aclk) disable iff (!aresetn)
      wr_third_pins && (wr_addr == A_THIRD_PINS) ##1 (third_dir[0] == 1'b0) && !third_off[0] && !third_periph_en[0]
      |-> third_pin_oe[0] && third_pin_out[0] == $past(wr_data[0]))
    else $error("latch write not on output pin");

  a_serial_priority:
    assert property (@(posedge aclk) disable iff (!aresetn)
      usart_tx_en && synchronous_serial_port_en && !third_off[6] |->
      third_pin_oe[6] && third_pin_out[6] == usart_tx_out)
    else $error("pin six priority wrong");

  a_input_tristate:
    assert property (@(posedge aclk) disable iff (!aresetn)
      fourth_dir[3] && !fourth_periph_en[3] |-> !fourth_pin_oe[3])
    else $error("fourth input pin driven");

  a_bias_no_drive:
    assert property (@(posedge aclk) disable iff (!aresetn)
      lcd_bias_input_en |-> third_pin_oe[2:0] == 3'h0)
    else $error("bias pin driven");

  a_pullup_output_off:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (weak_pullup_on & ~second_port_direction) == 8'h00)
    else $error("pull-up on output pin");

endmodule

// file: core/dbg_pkg.sv
package dbg_pkg;

  // Oscillator selection; code 2 is the RC or internal mode
  typedef enum logic [1:0] {
    dbg_osc_low_power  = 2'h0,
    dbg_osc_crystal    = 2'h1,
    dbg_osc_high_speed = 2'h3,
    dbg_osc_rc         = 2'h2
  } dbg_osc_type;

endpackage

// file: core/dbg_port_lane.sv
`include "dbg_defines.svh"

module dbg_port_lane #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         por_reset,
  input  wire logic         latch_we,
  input  wire logic         dir_we,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] latch_q,
  output logic      [W-1:0] dir_q,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] latch_ff;
  logic [W-1:0] dir_ff;
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Only a power-on or brown-out reset touches the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_ff <= W'(`DBG_DIR_RESET);
      if (por_reset) begin
        latch_ff <= W'(`DBG_LATCH_POR);
      end
    end else begin
      if (latch_we) begin
        latch_ff <= wr_data;
      end
      if (dir_we) begin
        dir_ff <= wr_data;
      end
    end
  end

  // Schmitt-buffered pins are digital here; two flops keep reads clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign latch_q  = latch_ff;
  assign dir_q    = dir_ff;
  assign pin_sync = sync_ff;

endmodule
